// ===== design/dsts_pkg.sv
// Shared constants and carrier types for the debug serial timeout and status block.
// What this block does
// - No handshake: uncollected read dropped after 512 clocks
// - Timed-out read data no longer offered
// - Handshake enabled: timeout suspended awaiting read data
// - Handshake pulse re-arms 512-clock collection timeout
// - Falling edge after timeout starts new frame
// - Partial transfer dropped after 512 clocks between edges
// - Port unusable while wait mode gates clocks
// - Wait clock restart: soft reset, handshake off
// - Stop mode: port down; restart resets, handshake off
// - Active flag: hardware sets, lookup table clears
// - Clock select written only by debug writes
// - Special single-chip: enable flag reads set when allowed
// - Special single-chip: unsecured flag equals secured-and-erased
// - Status register readable in every mode
package dsts_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [15:0] STATUS_ADDR = 16'hFF01;
   localparam int ENABLE_BIT = 7;
   localparam int ACTIVE_BIT = 6;
   localparam int CLKSEL_BIT = 2;
   localparam int UNSECURED_FLAG_BIT = 1;
   localparam logic STATUS_RESET_BIT = 1'b0;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // ----------------------------------------------------------------
   // Timing counts
   // ----------------------------------------------------------------
   localparam int TIMEOUT_SERIAL_CYCLES = 512;
   localparam int SERIAL_CLOCK_DIVIDE = 1;
   localparam int ACK_LOW_SERIAL_CYCLES = 16;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SRC_HW_CMD,
      SRC_FW_WRITE,
      SRC_FW_LOOKUP,
      SRC_OTHER
   } dsts_source_e;

   typedef enum logic [2:0] {
      XFER_IDLE,
      XFER_RX_CMD,
      XFER_WAIT_DATA,
      XFER_DATA_READY,
      XFER_TX_DATA
   } dsts_xfer_e;

   typedef struct packed {
      logic write;
      logic read;
      dsts_source_e source;
      logic [15:0] addr;
      logic [7:0] wrData;
   } dsts_reg_req_s;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } dsts_reg_rsp_s;

   typedef struct packed {
      logic cmdDone;
      logic cmdIsRead;
      logic dataReady;
      logic dataDone;
      logic ackOnCmd;
      logic ackOffCmd;
   } dsts_serial_ev_s;

endpackage

// ===== design/dsts_timeout_counter.sv
// Serial clock timeout counter that pulses after each run of LIMIT uninterrupted serial clocks, then wraps to zero and keeps counting.
`timescale 1ns/10ps
module dsts_timeout_counter #(
   parameter int LIMIT = dsts_pkg::TIMEOUT_SERIAL_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic serialTick,
   input wire logic run,
   input wire logic restart,
   output logic expired
);

   localparam int CW = $clog2(LIMIT);
   localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

   typedef struct packed {
      logic [CW-1:0] count;
      logic fired;
   } dsts_tmo_state_s;

   dsts_tmo_state_s state;
   dsts_tmo_state_s next_state;

   // ----------------------------------------------------------------
   // Counting
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_state.fired = 1'b0;
      if (restart || !run) begin
         // A stalled counter keeps no stale count, so every arm starts a full window.
         next_state.count = '0;
      end else if (serialTick) begin
         if (state.count == LAST) begin
            next_state.count = '0;
            next_state.fired = 1'b1;
         end else begin
            next_state.count = state.count + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign expired = state.fired;

endmodule

// ===== design/dsts_debug_port.sv
// Debug port transfer supervisor: serial timeout, handshake pulse, low-power recovery and status register.
`timescale 1ns/10ps
module dsts_debug_port #(
   parameter int TIMEOUT_CYCLES = dsts_pkg::TIMEOUT_SERIAL_CYCLES,
   parameter int SERIAL_DIV = dsts_pkg::SERIAL_CLOCK_DIVIDE,
   parameter int ACK_LOW_CYCLES = dsts_pkg::ACK_LOW_SERIAL_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic bgPinIn,
   output logic bgPinOut,
   output logic bgPinOe,
   input wire dsts_pkg::dsts_serial_ev_s serialEv,
   input wire dsts_pkg::dsts_reg_req_s regReq,
   output dsts_pkg::dsts_reg_rsp_s regRsp,
   input wire logic bdmEntry,
   input wire logic portClockGated,
   input wire logic stopMode,
   input wire logic specialSingleChip,
   input wire logic secured,
   input wire logic fullyErased,
   output logic serialTick,
   output logic softReset,
   output logic frameStart,
   output logic dataOffered,
   output logic ackPulse,
   output logic ackEnabled,
   output logic portUsable,
   output logic activeFlag,
   output logic clockSelect,
   output logic enableFlag,
   output logic unsecuredFlag
);

   localparam int DW = (SERIAL_DIV > 1) ? $clog2(SERIAL_DIV) : 1;
   localparam logic [DW-1:0] DIV_LAST = DW'(SERIAL_DIV - 1);
   localparam int AW = $clog2(ACK_LOW_CYCLES + 1);
   localparam logic [AW-1:0] ACK_LOAD = AW'(ACK_LOW_CYCLES);

   typedef struct packed {
      dsts_pkg::dsts_xfer_e xfer;
      logic [DW-1:0] div;
      logic tick;
      logic pinLast;
      logic haltedLast;
      logic ackOn;
      logic [AW-1:0] ackLow;
      logic ackPulse;
      logic softReset;
      logic frameStart;
      logic strapDone;
      logic active;
      logic clkSel;
      logic enable;
      dsts_pkg::dsts_reg_rsp_s rsp;
   } dsts_port_state_s;

   dsts_port_state_s state;
   dsts_port_state_s next_state;

   logic halted;
   logic pinFall;
   logic expired;
   logic tmoRun;
   logic tmoRestart;
   logic unsecNow;
   logic regHit;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic debugWriter(input dsts_pkg::dsts_source_e src);
      debugWriter = (src == dsts_pkg::SRC_HW_CMD) || (src == dsts_pkg::SRC_FW_WRITE);
   endfunction

   function automatic logic [7:0] statusByte(input logic en, input logic act, input logic cs, input logic un);
      logic [7:0] b;
      b = '0;
      b[dsts_pkg::ENABLE_BIT] = en;
      b[dsts_pkg::ACTIVE_BIT] = act;
      b[dsts_pkg::CLKSEL_BIT] = cs;
      b[dsts_pkg::UNSECURED_FLAG_BIT] = un;
      statusByte = b;
   endfunction

   // ----------------------------------------------------------------
   // Timeout
   // ----------------------------------------------------------------
   // Gated clocks freeze the transfer logic; no host pin edge or serial command is seen, though status register accesses still are.
   assign halted = portClockGated || stopMode;
   // The low phase of our own handshake pulse must not be taken for a host edge.
   assign pinFall = !halted && state.pinLast && !bgPinIn && state.ackLow == '0;

   // The wait for read data is exempt only while the handshake is on.
   always_comb begin
      tmoRun = !halted;
      unique case (state.xfer)
         dsts_pkg::XFER_IDLE: tmoRun = 1'b0;
         dsts_pkg::XFER_WAIT_DATA: tmoRun = !halted && !state.ackOn;
         default: tmoRun = !halted;
      endcase
   end

   assign tmoRestart = pinFall || state.ackPulse;

   dsts_timeout_counter #(
      .LIMIT(TIMEOUT_CYCLES)
   ) u_timeout (
      .clk(clk),
      .reset(reset),
      .serialTick(state.tick),
      .run(tmoRun),
      .restart(tmoRestart),
      .expired(expired)
   );

   assign unsecNow = specialSingleChip && secured && fullyErased;
   assign regHit = regReq.addr == dsts_pkg::STATUS_ADDR;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_state.softReset = 1'b0;
      next_state.frameStart = 1'b0;
      next_state.ackPulse = 1'b0;
      next_state.pinLast = bgPinIn;
      next_state.haltedLast = halted;
      next_state.tick = 1'b0;

      if (!halted) begin
         if (state.div == DIV_LAST) begin
            next_state.div = '0;
            next_state.tick = 1'b1;
         end else begin
            next_state.div = state.div + 1'b1;
         end
      end

      if (state.ackLow != '0 && state.tick && !halted) begin
         next_state.ackLow = state.ackLow - 1'b1;
      end

      if (serialEv.ackOnCmd && !halted) begin
         next_state.ackOn = 1'b1;
      end
      if (serialEv.ackOffCmd && !halted) begin
         next_state.ackOn = 1'b0;
      end

      if (halted) begin
         next_state.xfer = state.xfer;
      end else if (state.haltedLast) begin
         // Clocks back from wait or stop: drop everything and turn the handshake off.
         next_state.xfer = dsts_pkg::XFER_IDLE;
         next_state.softReset = 1'b1;
         next_state.ackOn = 1'b0;
         next_state.ackLow = '0;
      end else if (expired) begin
         next_state.xfer = dsts_pkg::XFER_IDLE;
         next_state.softReset = 1'b1;
         next_state.ackLow = '0;
         if (pinFall) begin
            next_state.xfer = dsts_pkg::XFER_RX_CMD;
            next_state.frameStart = 1'b1;
         end
      end else begin
         unique case (state.xfer)
            dsts_pkg::XFER_IDLE: begin
               if (pinFall) begin
                  next_state.xfer = dsts_pkg::XFER_RX_CMD;
                  next_state.frameStart = 1'b1;
               end
            end
            dsts_pkg::XFER_RX_CMD: begin
               if (serialEv.cmdDone) begin
                  next_state.xfer = serialEv.cmdIsRead ? dsts_pkg::XFER_WAIT_DATA : dsts_pkg::XFER_IDLE;
               end
            end
            dsts_pkg::XFER_WAIT_DATA: begin
               if (serialEv.dataReady) begin
                  next_state.xfer = dsts_pkg::XFER_DATA_READY;
                  if (state.ackOn) begin
                     next_state.ackPulse = 1'b1;
                     next_state.ackLow = ACK_LOAD;
                  end
               end
            end
            dsts_pkg::XFER_DATA_READY: begin
               if (pinFall) begin
                  next_state.xfer = dsts_pkg::XFER_TX_DATA;
               end
            end
            dsts_pkg::XFER_TX_DATA: begin
               if (serialEv.dataDone) begin
                  next_state.xfer = dsts_pkg::XFER_IDLE;
               end
            end
         endcase
      end

      // Hardware loads the enable flag from the mode and security inputs in the first cycle after reset.
      if (!state.strapDone) begin
         next_state.strapDone = 1'b1;
         next_state.enable = specialSingleChip && (!secured || fullyErased);
      end

      if (regReq.write && regHit) begin
         if (debugWriter(regReq.source)) begin
            next_state.clkSel = regReq.wrData[dsts_pkg::CLKSEL_BIT];
         end
         if (debugWriter(regReq.source) || regReq.source == dsts_pkg::SRC_FW_LOOKUP) begin
            next_state.enable = regReq.wrData[dsts_pkg::ENABLE_BIT];
         end
         if (regReq.source == dsts_pkg::SRC_FW_LOOKUP && !regReq.wrData[dsts_pkg::ACTIVE_BIT]) begin
            next_state.active = 1'b0;
         end
      end
      // Entry wins over a simultaneous exit so an entry is never lost.
      if (bdmEntry) begin
         next_state.active = 1'b1;
      end

      // Reads are answered in every mode, even with the port clocks gated.
      next_state.rsp.valid = regReq.read;
      if (regHit) begin
         next_state.rsp.data = statusByte(state.enable, state.active, state.clkSel, unsecNow);
      end else begin
         next_state.rsp.data = dsts_pkg::UNMAPPED_READ;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state <= '0;
         state.xfer <= dsts_pkg::XFER_IDLE;
         state.pinLast <= 1'b1;
         state.active <= dsts_pkg::STATUS_RESET_BIT;
         state.clkSel <= dsts_pkg::STATUS_RESET_BIT;
         state.enable <= dsts_pkg::STATUS_RESET_BIT;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Only the handshake low phase is driven here; the bit engine owns data bits.
   assign bgPinOut = 1'b0;
   assign bgPinOe = state.ackLow != '0;
   assign serialTick = state.tick;
   assign softReset = state.softReset;
   assign frameStart = state.frameStart;
   assign dataOffered = !halted && (state.xfer == dsts_pkg::XFER_DATA_READY
                                    || state.xfer == dsts_pkg::XFER_TX_DATA);
   assign ackPulse = state.ackPulse;
   assign ackEnabled = state.ackOn;
   assign portUsable = !halted;
   assign activeFlag = state.active;
   assign clockSelect = state.clkSel;
   assign enableFlag = state.enable;
   assign unsecuredFlag = unsecNow;
   assign regRsp = state.rsp;

endmodule

// ===== sim/dsts_debug_port_monitor.sv
// Concurrent checks on the ports of the debug port supervisor.
`timescale 1ns/10ps
module dsts_debug_port_monitor #(
   parameter int TIMEOUT_CYCLES = 512
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic bgPinIn,
   input wire dsts_pkg::dsts_serial_ev_s serialEv,
   input wire dsts_pkg::dsts_reg_req_s regReq,
   input wire dsts_pkg::dsts_reg_rsp_s regRsp,
   input wire logic bdmEntry,
   input wire logic portClockGated,
   input wire logic stopMode,
   input wire logic specialSingleChip,
   input wire logic secured,
   input wire logic fullyErased,
   input wire logic softReset,
   input wire logic frameStart,
   input wire logic ackEnabled,
   input wire logic portUsable,
   input wire logic activeFlag,
   input wire logic clockSelect,
   input wire logic enableFlag,
   input wire logic unsecuredFlag
);
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // The stall windows below are unrolled for a timeout count of 8, the value the bench uses.
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   wire logic halted = portClockGated | stopMode;
   wire logic hit = regReq.write && regReq.addr == dsts_pkg::STATUS_ADDR;
   sequence s_quiet;
      bgPinIn && !halted && !ackEnabled;
   endsequence
   sequence s_rx_stall;
      frameStart ##1 s_quiet [*8];
   endsequence
   sequence s_read_wait;
      serialEv.cmdDone && serialEv.cmdIsRead && ackEnabled && !halted ##1 (bgPinIn && !serialEv.dataReady && !halted) [*8];
   endsequence
   property p_rx_timeout;
      s_rx_stall |-> ##[0:4] softReset;
   endproperty
   a_rx_timeout: assert property (p_rx_timeout) else $error("stalled frame not dropped");
   property p_suspend;
      s_read_wait |=> (!softReset) [*4];
   endproperty
   a_suspend: assert property (p_suspend) else $error("timeout ran while awaiting data");
   property p_new_frame;
      softReset ##1 bgPinIn ##1 (!bgPinIn && !halted) |=> frameStart;
   endproperty
   a_new_frame: assert property (p_new_frame) else $error("falling edge not taken as new frame");
   property p_usable;
      portUsable == !halted;
   endproperty
   a_usable: assert property (p_usable) else $error("port usable while halted");
   property p_recover;
      $fell(halted) |-> ##[1:2] (softReset && !ackEnabled);
   endproperty
   a_recover: assert property (p_recover) else $error("no soft reset on clock restart");
   property p_unsecured_flag;
      unsecuredFlag == (specialSingleChip && secured && fullyErased);
   endproperty
   a_unsecured_flag: assert property (p_unsecured_flag) else $error("unsecured flag wrong");
   property p_active_set;
      $rose(activeFlag) |-> $past(bdmEntry);
   endproperty
   a_active_set: assert property (p_active_set) else $error("active flag set without entry");
   property p_clksel;
      $changed(clockSelect) && !$past(reset) |-> $past(hit && regReq.source inside {dsts_pkg::SRC_HW_CMD,
         dsts_pkg::SRC_FW_WRITE});
   endproperty
   a_clksel: assert property (p_clksel) else $error("clock select changed by other source");
   property p_read;
      regReq.read && regReq.addr == dsts_pkg::STATUS_ADDR |=> regRsp.valid &&
         regRsp.data == $past({enableFlag, activeFlag, 3'h0, clockSelect, unsecuredFlag, 1'b0});
   endproperty
   a_read: assert property (p_read) else $error("status read wrong");
endmodule
bind dsts_debug_port dsts_debug_port_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_dsts_debug_port_monitor (
   .clk, .reset, .bgPinIn, .serialEv, .regReq, .regRsp, .bdmEntry, .portClockGated, .stopMode,
   .specialSingleChip, .secured, .fullyErased, .softReset, .frameStart, .ackEnabled, .portUsable,
   .activeFlag, .clockSelect, .enableFlag, .unsecuredFlag);

// ===== sim/dsts_host_model.sv
// Behavioural debug host on the open-drain background pin.
`timescale 1ns/10ps
module dsts_host_model (
   input wire logic clk,
   input wire logic targetOe,
   output logic pinLevel
);
   // ----------------------------------------
   // Wire
   // ----------------------------------------
   logic hostLow = 1'b0;
   // The pull-up wins whenever neither party pulls the wire low.
   assign pinLevel = !(hostLow || targetOe);
   task automatic pulse_low(input int cycles);
      hostLow <= 1'b1;
      repeat (cycles) @(posedge clk);
      hostLow <= 1'b0;
   endtask
endmodule

// ===== sim/debug_serial_timeout_status_test.sv
// Self-checking bench for the debug port supervisor.
`timescale 1ns/10ps
module debug_serial_timeout_status_test;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic clk, reset, bgPinIn, bdmEntry, portClockGated, stopMode, specialSingleChip, secured, fullyErased;
   logic bgPinOe, softReset, dataOffered, ackEnabled, portUsable;
   logic frameStart, ackPulse, activeFlag, clockSelect, enableFlag, unsecuredFlag;
   dsts_pkg::dsts_serial_ev_s serialEv;
   dsts_pkg::dsts_reg_req_s regReq;
   dsts_pkg::dsts_reg_rsp_s regRsp;
   int n_mismatch = 0;
   int n_checks = 0;
   int nSoft = 0;
   int nFrame = 0;
   int baseFrame;
   logic [2:0] tMode [3] = '{3'h6, 3'h4, 3'h3};
   logic [7:0] tFin [3] = '{8'h00, 8'h80, 8'h00};
   int cycles = 0;
   int base;
   logic [1:0] tSrc [6] = '{2'h3, 2'h2, 2'h0, 2'h1, 2'h1, 2'h0};
   logic [7:0] tDat [6] = '{8'h84, 8'h84, 8'h84, 8'h80, 8'h84, 8'h80};
   logic [7:0] tExp [6] = '{8'h82, 8'h82, 8'h86, 8'h82, 8'h86, 8'h82};
   dsts_debug_port #(.TIMEOUT_CYCLES(8), .ACK_LOW_CYCLES(2)) i_dsts_debug_port (
      .clk, .reset, .bgPinIn, .bgPinOut(), .bgPinOe, .serialEv, .regReq, .regRsp, .bdmEntry,
      .portClockGated, .stopMode, .specialSingleChip, .secured, .fullyErased, .serialTick(), .softReset,
      .frameStart, .dataOffered, .ackPulse, .ackEnabled, .portUsable, .activeFlag, .clockSelect,
      .enableFlag, .unsecuredFlag);
   dsts_host_model i_dsts_host_model (.clk(clk), .targetOe(bgPinOe), .pinLevel(bgPinIn));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic summarize();
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [1:0] src, input logic [7:0] data);
      regReq <= '{1'b1, 1'b0, dsts_pkg::dsts_source_e'(src), dsts_pkg::STATUS_ADDR, data};
      @(posedge clk);
      regReq.write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [15:0] addr, input logic [7:0] exp);
      regReq.read <= 1'b1;
      regReq.addr <= addr;
      @(posedge clk);
      regReq.read <= 1'b0;
      @(posedge clk);
      chk("valid", 8'(regRsp.valid), 8'h01);
      chk("status", regRsp.data, exp);
   endtask
   task automatic ev(input logic [5:0] e);
      serialEv <= e;
      @(posedge clk);
      serialEv <= '0;
      @(posedge clk);
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (softReset === 1'b1) begin
         nSoft <= nSoft + 1;
      end
      if (frameStart === 1'b1) begin
         nFrame <= nFrame + 1;
      end
      if (cycles == 3000) begin
         n_mismatch++;
         summarize();
      end
   end
   initial begin
      reset = 1'b1;
      serialEv = '0;
      regReq = '0;
      {bdmEntry, portClockGated, stopMode} = 3'h0;
      {specialSingleChip, secured, fullyErased} = 3'h7;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
      rd(dsts_pkg::STATUS_ADDR, 8'h82);
      chk("enable", 8'(enableFlag), 8'h01);
      chk("unsecured_flag", 8'(unsecuredFlag), 8'h01);
      for (int i = 0; i < 6; i++) begin
         wr(tSrc[i], tDat[i]);
         rd(dsts_pkg::STATUS_ADDR, tExp[i]);
         chk("clksel", 8'(clockSelect), {7'h0, tExp[i][2]});
      end
      rd(16'hFF02, 8'h00);
      bdmEntry <= 1'b1;
      @(posedge clk);
      bdmEntry <= 1'b0;
      wr(2'h1, 8'h80);
      rd(dsts_pkg::STATUS_ADDR, 8'hC2);
      chk("active", 8'(activeFlag), 8'h01);
      wr(2'h2, 8'h80);
      rd(dsts_pkg::STATUS_ADDR, 8'h82);
      i_dsts_host_model.pulse_low(1);
      ev(6'h30);
      ev(6'h08);
      chk("offered", 8'(dataOffered), 8'h01);
      repeat (12) @(posedge clk);
      chk("dropped", 8'(dataOffered), 8'h00);
      base = nSoft;
      baseFrame = nFrame;
      i_dsts_host_model.pulse_low(1);
      for (int k = 0; k < 20 && softReset !== 1'b1; k++) @(posedge clk);
      @(posedge clk);
      i_dsts_host_model.pulse_low(1);
      repeat (20) @(posedge clk);
      chk("partial", 8'(nSoft - base), 8'h02);
      chk("frames", 8'(nFrame - baseFrame), 8'h02);
      ev(6'h02);
      i_dsts_host_model.pulse_low(1);
      ev(6'h30);
      base = nSoft;
      repeat (30) @(posedge clk);
      chk("suspend", 8'(nSoft - base), 8'h00);
      ev(6'h08);
      chk("acked", 8'(dataOffered), 8'h01);
      chk("ackpulse", 8'(ackPulse), 8'h01);
      chk("ackdrive", 8'(bgPinOe), 8'h01);
      repeat (16) @(posedge clk);
      chk("ackdrop", 8'(dataOffered), 8'h00);
      for (int i = 0; i < 2; i++) begin
         ev(6'h02);
         chk("ackon", 8'(ackEnabled), 8'h01);
         {portClockGated, stopMode} <= i ? 2'h1 : 2'h2;
         repeat (3) @(posedge clk);
         chk("usable", 8'(portUsable), 8'h00);
         {portClockGated, stopMode} <= 2'h0;
         repeat (3) @(posedge clk);
         chk("ackoff", 8'(ackEnabled), 8'h00);
      end
      for (int i = 0; i < 3; i++) begin
         {specialSingleChip, secured, fullyErased} <= tMode[i];
         reset <= 1'b1;
         @(posedge clk);
         reset <= 1'b0;
         repeat (2) @(posedge clk);
         rd(dsts_pkg::STATUS_ADDR, tFin[i]);
         chk("unsecured_flag", 8'(unsecuredFlag), 8'h00);
      end
      summarize();
   end
endmodule
